// ===== design/acqseq_set_check.sv
`timescale 1ns/1ns
module acqseq_set_check
    import acqseq_pkg::*;
#(
    parameter int VW = FEAT_VW
) (
    // Candidate set and reference settings
    input  wire logic [NFEAT-1:0][VW-1:0] cand,
    input  wire logic [NFEAT-1:0][VW-1:0] refv,
    // Classification
    input  wire logic [NFEAT-1:0]         range_mask,
    input  wire logic [NFEAT-1:0]         fix_mask,
    // Result
    output logic                          ok
);
    // Sequenced values stay in range; fixed ones must agree with the reference
    always_comb begin
        ok = 1'b1;
        for (int f = 0; f < NFEAT; f++) begin
            if (range_mask[f] && (cand[f] > VW'(VAL_MAX))) begin
                ok = 1'b0;
            end
            if (fix_mask[f] && (cand[f] != refv[f])) begin
                ok = 1'b0;
            end
        end
    end
endmodule : acqseq_set_check

// ===== design/acqseq_step_event.sv
`timescale 1ns/1ns
module acqseq_step_event
    import acqseq_pkg::*;
#(
    parameter int NS = NSRC
) (
    // Clock and reset
    input  wire logic          clk,
    input  wire logic          rst,
    // Event sources and selection
    input  wire logic [NS-1:0] src_lvl,
    input  wire logic [1:0]    src_sel,
    input  wire logic [1:0]    edge_mode,
    // Detected events
    output logic               hit,
    output logic [NS-1:0]      rise
);
    typedef struct packed {
        logic [NS-1:0] prev;
    } acqseq_evt_type;

    acqseq_evt_type s_r;
    acqseq_evt_type s_nxt;
    logic           cur;
    logic           old;

    always_comb begin
        s_nxt      = s_r;
        s_nxt.prev = src_lvl;
        cur        = src_lvl[src_sel];
        old        = s_r.prev[src_sel];
        rise       = src_lvl & ~s_r.prev;
        case (edge_mode)
            EDGE_RISE: hit = cur & ~old;
            EDGE_FALL: hit = ~cur & old;
            EDGE_ANY:  hit = cur ^ old;
            EDGE_HIGH: hit = cur;
            default:   hit = 1'b0;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule : acqseq_step_event

// ===== design/acqseq_top.sv
// Notes on behaviour
// - Up to eight parameter sets are stored, each configured and saved apart.
// - Every set owns one transition path; the path pick accepts only path zero.
// - An enabled sequenced feature takes part in every stored set.
// - Entering setup classifies implied and fixed features and locks fixed ones.
// - Store copies live settings into the picked set and flags its validity.
// - A store may invalidate other previously valid sets; their flags follow.
// - Recall copies a valid picked set into live settings at any time.
// - A path holds event source, activation mode and successor set index.
// - The first set register names the set active when a run begins.
// - Leaving setup checks the whole configuration and reports it.
// - Implied features are recorded per set, writable in setup, locked in a run.
// - Fixed features keep one value and are locked in setup and in a run.
// - Forced automatic features are held off during a run, writable in setup.
// - Direct feature values are stored per set and may differ between sets.
// - A stored set captures configured and dependent live settings alike.
// - Path and set contents may be written in any order, set pick decides.
// - Non-sequenced features are not loaded at run start or on steps; all but forced ones stay writable.
// - Run on locks sequenced features, loads the first set, then steps on events.
// - Run off ends the run and leaves live settings from the last set.
`timescale 1ns/1ns
module acqseq_top
    import acqseq_pkg::*;
#(
    parameter int VW = FEAT_VW
) (
    // Clock and reset
    input  wire logic                      CLK,
    input  wire logic                      SYS_RST,
    // APB slave
    input  wire logic                      PSEL,
    input  wire logic                      PENABLE,
    input  wire logic                      PWRITE,
    input  wire logic [ADDR_W-1:0]         PADDR,
    input  wire logic [31:0]               PWDATA,
    output logic [31:0]                    PRDATA,
    output logic                           PREADY,
    output logic                           PSLVERR,
    // Acquisition events and status
    input  wire logic [NSRC-1:0]           EVT_IN,
    input  wire logic                      STREAMING,
    // Live settings and sequencer state
    output logic [NFEAT-1:0][VW-1:0]       FEAT_VALUE,
    output logic [2:0]                     ACTIVE_SET,
    output logic                           RUN_ON,
    output logic                           SETUP_ON
);
    typedef struct packed {
        logic                              setup;
        logic                              run;
        logic                              setup_ok;
        logic                              pending;
        logic [2:0]                        fpick;
        logic [2:0]                        spick;
        logic [2:0]                        first;
        logic [2:0]                        active;
        logic [NFEAT-1:0]                  direct_en;
        logic [NFEAT-1:0]                  direct;
        logic [NFEAT-1:0]                  implied;
        logic [NFEAT-1:0]                  fixed;
        logic [NSET-1:0]                   ok;
        logic [NSET-1:0][PATH_W-1:0]       path;
        logic [NSET-1:0][NFEAT-1:0][VW-1:0] sets;
        logic [NFEAT-1:0][VW-1:0]          live;
        logic                              pready;
        logic                              pslverr;
        logic [31:0]                       prdata;
    } acqseq_state_type;

    acqseq_state_type s_r;
    acqseq_state_type s_nxt;

    logic [NSET-1:0]  chk_set;
    logic             chk_live;
    logic [NFEAT-1:0] impl_c;
    logic [NFEAT-1:0] fix_c;
    logic [NFEAT-1:0] seq_m;
    logic [NFEAT-1:0] wr_ok;
    logic             cfg_ok;
    logic             step_hit;
    logic [NSRC-1:0]  src_rise;
    logic [31:0]      rd_word;
    logic             rd_hit;
    logic             access;
    logic             wr;
    logic [2:0]       ca_idx;
    logic [2:0]       waddr_f;
    logic             feat_addr;
    logic [PATH_W-1:0] act_path;

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    assign seq_m     = s_r.direct | s_r.implied | s_r.fixed;
    assign act_path  = s_r.path[s_r.active];
    assign feat_addr = (PADDR[7:5] == OFS_FEAT_BASE[7:5]);
    assign waddr_f   = PADDR[4:2];
    assign access    = PSEL & PENABLE & ~s_r.pready;
    assign wr        = PSEL & PENABLE & s_r.pready & PWRITE;

    function automatic logic [NFEAT-1:0][VW-1:0] load_set(
        input logic [NFEAT-1:0][VW-1:0] cur,
        input logic [NFEAT-1:0][VW-1:0] setv,
        input logic [NFEAT-1:0]         mask
    );
        logic [NFEAT-1:0][VW-1:0] res;
        res = cur;
        for (int f = 0; f < NFEAT; f++) begin
            if (mask[f]) begin
                res[f] = setv[f];
            end
        end
        return res;
    endfunction : load_set

    acqseq_step_event #(
        .NS        (NSRC)
    ) u_evt (
        .clk       (CLK),
        .rst       (SYS_RST),
        .src_lvl   (EVT_IN),
        .src_sel   (act_path[PATH_SRC_LSB +: 2]),
        .edge_mode (act_path[PATH_EDGE_LSB +: 2]),
        .hit       (step_hit),
        .rise      (src_rise)
    );

    // Each stored set re-checked against the live fixed values
    for (genvar i = 0; i < NSET; i++) begin : g_chk
        acqseq_set_check #(
            .VW         (VW)
        ) u_chk (
            .cand       (s_r.sets[i]),
            .refv       (s_r.live),
            .range_mask (s_r.direct | s_r.implied),
            .fix_mask   (s_r.fixed),
            .ok         (chk_set[i])
        );
    end

    acqseq_set_check #(
        .VW         (VW)
    ) u_chk_live (
        .cand       (s_r.live),
        .refv       (s_r.live),
        .range_mask (s_r.direct | s_r.implied),
        .fix_mask   (s_r.fixed),
        .ok         (chk_live)
    );

    // Classification of the dependency web from the enabled direct features
    always_comb begin
        impl_c = '0;
        fix_c  = '0;
        for (int f = 0; f < NFEAT; f++) begin
            if (s_r.direct_en[f]) begin
                impl_c = impl_c | IMPL_MAP[f];
            end
        end
        impl_c = impl_c & ~s_r.direct_en;
        // Repeated sweep: preconditions of fixed features become fixed as well
        for (int k = 0; k < NFEAT; k++) begin
            for (int f = 0; f < NFEAT; f++) begin
                if (s_r.direct_en[f] || impl_c[f] || fix_c[f]) begin
                    fix_c = fix_c | FIX_MAP[f];
                end
            end
        end
        fix_c = fix_c & ~(s_r.direct_en | impl_c);
    end

    // Whole configuration: every set reached from the first one is valid
    always_comb begin
        cfg_ok = 1'b1;
        ca_idx = s_r.first;
        for (int k = 0; k < NSET; k++) begin
            cfg_ok = cfg_ok & s_r.ok[ca_idx];
            ca_idx = s_r.path[ca_idx][PATH_NEXT_LSB +: 3];
        end
    end

    // Write permission per live feature
    always_comb begin
        for (int f = 0; f < NFEAT; f++) begin
            if (s_r.run) begin
                wr_ok[f] = ~(seq_m[f] | FORCED_MAP[f]);
            end else if (s_r.setup) begin
                wr_ok[f] = ~s_r.fixed[f];
            end else begin
                wr_ok[f] = 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register read decode

    always_comb begin
        rd_word = 32'h0;
        rd_hit  = 1'b1;
        if (feat_addr) begin
            rd_word[VW-1:0] = s_r.live[waddr_f];
        end else begin
            case (PADDR)
                OFS_CTRL: begin
                    rd_word[CTRL_SETUP_BIT] = s_r.setup;
                    rd_word[CTRL_RUN_BIT]   = s_r.run;
                end
                OFS_STATUS: begin
                    rd_word[ST_SETUP_OK_BIT]         = s_r.setup_ok;
                    rd_word[ST_SET_OK_BIT]           = s_r.ok[s_r.spick];
                    rd_word[ST_ACTIVE_LSB +: 3]      = s_r.active;
                    rd_word[ST_OKS_LSB +: NSET]      = s_r.ok;
                end
                OFS_FEAT_PICK: rd_word[2:0]        = s_r.fpick;
                OFS_FEAT_EN:   rd_word[0]          = s_r.direct_en[s_r.fpick];
                OFS_SET_PICK:  rd_word[2:0]        = s_r.spick;
                OFS_PATH_PICK: rd_word             = 32'h0;
                OFS_PATH:      rd_word[PATH_W-1:0] = s_r.path[s_r.spick];
                OFS_FIRST_SET: rd_word[2:0]        = s_r.first;
                OFS_CLASS:     rd_word = {FORCED_MAP, s_r.fixed, s_r.implied, s_r.direct};
                default:       rd_hit  = 1'b0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        s_nxt         = s_r;
        s_nxt.pready  = 1'b0;
        s_nxt.pslverr = 1'b0;
        s_nxt.prdata  = 32'h0;
        // One wait state keeps every APB output registered
        if (access) begin
            s_nxt.pready  = 1'b1;
            s_nxt.prdata  = rd_word;
            s_nxt.pslverr = ~rd_hit;
        end
        // Pending values land at the frame start, before a new step is taken
        if (s_r.run && s_r.pending && src_rise[SRC_FRAME_START]) begin
            s_nxt.live    = load_set(s_r.live, s_r.sets[s_r.active], seq_m);
            s_nxt.pending = 1'b0;
        end
        if (s_r.run && step_hit) begin
            s_nxt.active  = act_path[PATH_NEXT_LSB +: 3];
            s_nxt.pending = 1'b1;
        end
        if (wr && feat_addr) begin
            if (wr_ok[waddr_f]) begin
                s_nxt.live[waddr_f] = PWDATA[VW-1:0];
            end
        end else if (wr) begin
            case (PADDR)
                OFS_CTRL: begin
                    if (PWDATA[CTRL_SETUP_BIT] && !s_r.setup && !s_r.run) begin
                        s_nxt.setup    = 1'b1;
                        s_nxt.setup_ok = 1'b0;
                        s_nxt.direct   = s_r.direct_en;
                        s_nxt.implied  = impl_c;
                        s_nxt.fixed    = fix_c;
                    end else if (!PWDATA[CTRL_SETUP_BIT] && s_r.setup) begin
                        s_nxt.setup    = 1'b0;
                        s_nxt.setup_ok = cfg_ok;
                    end
                    if (PWDATA[CTRL_RUN_BIT] && !s_r.run && !s_r.setup
                        && s_r.setup_ok && !STREAMING) begin
                        s_nxt.run     = 1'b1;
                        s_nxt.active  = s_r.first;
                        s_nxt.pending = 1'b0;
                        s_nxt.live    = load_set(s_r.live, s_r.sets[s_r.first], seq_m);
                    end else if (!PWDATA[CTRL_RUN_BIT] && s_r.run) begin
                        s_nxt.run     = 1'b0;
                        s_nxt.pending = 1'b0;
                    end
                    // Store only while configuring, so classification is settled
                    if (PWDATA[CTRL_STORE_BIT] && s_r.setup) begin
                        s_nxt.sets[s_r.spick] = s_r.live;
                        s_nxt.ok              = s_r.ok & chk_set;
                        s_nxt.ok[s_r.spick]   = chk_live;
                    end
                    if (PWDATA[CTRL_RECALL_BIT] && s_r.ok[s_r.spick]) begin
                        s_nxt.live = s_r.sets[s_r.spick];
                    end
                end
                OFS_FEAT_PICK: s_nxt.fpick = PWDATA[2:0];
                OFS_FEAT_EN: begin
                    // Classification is frozen once setup is entered
                    if (!s_r.setup && !s_r.run) begin
                        s_nxt.direct_en[s_r.fpick] = PWDATA[0];
                    end
                end
                OFS_SET_PICK: s_nxt.spick = PWDATA[2:0];
                OFS_PATH: begin
                    if (!s_r.run) begin
                        s_nxt.path[s_r.spick] = PWDATA[PATH_W-1:0];
                    end
                end
                OFS_FIRST_SET: begin
                    if (!s_r.run) begin
                        s_nxt.first = PWDATA[2:0];
                    end
                end
                default: s_nxt.path = s_nxt.path;
            endcase
        end
        if (s_nxt.run) begin
            for (int f = 0; f < NFEAT; f++) begin
                if (FORCED_MAP[f]) begin
                    s_nxt.live[f] = '0;
                end
            end
        end
    end

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign PRDATA     = s_r.prdata;
    assign PREADY     = s_r.pready;
    assign PSLVERR    = s_r.pslverr;
    assign FEAT_VALUE = s_r.live;
    assign ACTIVE_SET = s_r.active;
    assign RUN_ON     = s_r.run;
    assign SETUP_ON   = s_r.setup;

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);

    logic fwr;
    assign fwr = wr & feat_addr;
    property p_fix_setup;
        fwr && s_r.setup && s_r.fixed[waddr_f] |=> s_r.live[$past(waddr_f)]
            == $past(s_r.live[waddr_f]);
    endproperty
    a_fix_setup: assert property (p_fix_setup) else $error("fixed written in setup");
    property p_lock_run;
        fwr && s_r.run && seq_m[waddr_f] && !src_rise[SRC_FRAME_START]
            |=> s_r.live[$past(waddr_f)] == $past(s_r.live[waddr_f]);
    endproperty
    a_lock_run: assert property (p_lock_run) else $error("locked written in run");
    property p_forced_off;
        s_r.run |-> (s_r.live[5] == '0);
    endproperty
    a_forced_off: assert property (p_forced_off) else $error("forced not off");
    property p_store_flag;
        wr && !feat_addr && PADDR == OFS_CTRL && PWDATA[CTRL_STORE_BIT] && s_r.setup
            |=> s_r.ok[$past(s_r.spick)] == $past(chk_live);
    endproperty
    a_store_flag: assert property (p_store_flag) else $error("set flag wrong");
    property p_store_others;
        wr && !feat_addr && PADDR == OFS_CTRL && PWDATA[CTRL_STORE_BIT] && s_r.setup
            |=> ((s_r.ok & ~$past(s_r.ok)) & ~(NSET'(1) << $past(s_r.spick))) == '0;
    endproperty
    a_store_others: assert property (p_store_others) else $error("set revived");
    property p_cfg_check;
        $fell(s_r.setup) |-> s_r.setup_ok == $past(cfg_ok);
    endproperty
    a_cfg_check: assert property (p_cfg_check) else $error("config flag wrong");
    property p_run_start;
        $rose(s_r.run) |-> s_r.active == $past(s_r.first) && !s_r.pending;
    endproperty
    a_run_start: assert property (p_run_start) else $error("wrong first set");
    property p_run_gate;
        $rose(s_r.run) |-> $past(s_r.setup_ok) && !$past(STREAMING);
    endproperty
    a_run_gate: assert property (p_run_gate) else $error("run started illegally");
    property p_step_only;
        $changed(s_r.active) && !$rose(s_r.run) |-> $past(s_r.run) && $past(step_hit);
    endproperty
    a_step_only: assert property (p_step_only) else $error("active moved");

    c_store: cover property (wr && PADDR == OFS_CTRL && PWDATA[CTRL_STORE_BIT] && s_r.setup);
    c_run:   cover property ($rose(s_r.run));
    c_step:  cover property (s_r.run && step_hit ##[1:50] s_r.run && step_hit);
    c_apply: cover property ($fell(s_r.pending) && s_r.run);
endmodule : acqseq_top

// ===== pkg/acqseq_pkg.sv
package acqseq_pkg;
    // Sizes
    localparam int NSET    = 8;
    localparam int NFEAT   = 8;
    localparam int FEAT_VW = 16;
    localparam int NSRC    = 4;
    localparam int PATH_W  = 7;
    localparam int ADDR_W  = 8;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL      = 8'h00;
    localparam logic [7:0] OFS_STATUS    = 8'h04;
    localparam logic [7:0] OFS_FEAT_PICK = 8'h08;
    localparam logic [7:0] OFS_FEAT_EN   = 8'h0C;
    localparam logic [7:0] OFS_SET_PICK  = 8'h10;
    localparam logic [7:0] OFS_PATH_PICK = 8'h14;
    localparam logic [7:0] OFS_PATH      = 8'h18;
    localparam logic [7:0] OFS_FIRST_SET = 8'h1C;
    localparam logic [7:0] OFS_CLASS     = 8'h20;
    localparam logic [7:0] OFS_FEAT_BASE = 8'h40;

    // Control and status fields
    localparam int CTRL_SETUP_BIT  = 0;
    localparam int CTRL_RUN_BIT    = 1;
    localparam int CTRL_STORE_BIT  = 2;
    localparam int CTRL_RECALL_BIT = 3;
    localparam int ST_SETUP_OK_BIT = 0;
    localparam int ST_SET_OK_BIT   = 1;
    localparam int ST_ACTIVE_LSB   = 8;
    localparam int ST_OKS_LSB      = 16;

    // Path word fields
    localparam int PATH_SRC_LSB  = 0;
    localparam int PATH_EDGE_LSB = 2;
    localparam int PATH_NEXT_LSB = 4;

    // Step event activation modes
    localparam logic [1:0] EDGE_RISE = 2'h0;
    localparam logic [1:0] EDGE_FALL = 2'h1;
    localparam logic [1:0] EDGE_ANY  = 2'h2;
    localparam logic [1:0] EDGE_HIGH = 2'h3;

    // Event source that marks a new frame
    localparam int SRC_FRAME_START = 0;

    // Feature dependency web: direct f implies IMPL_MAP[f]; f needs FIX_MAP[f] fixed
    localparam logic [NFEAT-1:0] IMPL_MAP [NFEAT] = '{8'h02, 8'h04, 8'h00, 8'h10,
                                                     8'h00, 8'h00, 8'h00, 8'h00};
    localparam logic [NFEAT-1:0] FIX_MAP [NFEAT]  = '{8'h00, 8'h01, 8'h80, 8'h00,
                                                     8'h00, 8'h00, 8'h00, 8'h40};
    // Automatic features held in manual mode during a run
    localparam logic [NFEAT-1:0] FORCED_MAP = 8'h20;
    localparam logic [FEAT_VW-1:0] VAL_MAX  = 16'hFFF0;
endpackage : acqseq_pkg

// ===== testbench/acqseq_top_tb_top.sv
`timescale 1ns/1ns
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_total++; \
    $display("unexpected at %0t: got %0h expected %0h", $time, (a), (b)); end end
module acqseq_top_tb_top;
    import acqseq_pkg::*;
    logic                          CLK = 1'b0;
    logic                          SYS_RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
    logic [ADDR_W-1:0]             PADDR;
    logic [31:0]                   PWDATA, PRDATA, rdat;
    logic [NSRC-1:0]               EVT_IN;
    logic                          STREAMING, RUN_ON, SETUP_ON, perr;
    logic [NFEAT-1:0][FEAT_VW-1:0] FEAT_VALUE;
    logic [2:0]                    ACTIVE_SET;
    int                            err_total = 0;
    int                            comparisons = 0;
    int                            cyc = 0;
    logic [15:0]                   vals [3] = '{16'h0100, 16'h0300, 16'hFFFF};
    logic [31:0]                   st_exp [3] = '{32'h00010002, 32'h00030002, 32'h00030000};

    always #2 CLK = ~CLK;

    acqseq_top #(.VW(FEAT_VW)) acqseq_top_inst (
        .CLK(CLK), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
        .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
        .EVT_IN(EVT_IN), .STREAMING(STREAMING), .FEAT_VALUE(FEAT_VALUE),
        .ACTIVE_SET(ACTIVE_SET), .RUN_ON(RUN_ON), .SETUP_ON(SETUP_ON));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : summarize

    // Hangs on a missing PREADY end here instead of running forever
    always @(posedge CLK) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            summarize();
        end
    end

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK);
        PSEL    <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE  <= wr;
        PADDR   <= a;
        PWDATA  <= d;
        @(posedge CLK);
        PENABLE <= 1'b1;
        do @(posedge CLK); while (PREADY !== 1'b1);
        rdat = PRDATA;
        perr = PSLVERR;
        PSEL    <= 1'b0;
        PENABLE <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(rdat, e)
    endtask : rdc

    function automatic logic [7:0] feat(input int f);
        return OFS_FEAT_BASE + 8'(4 * f);
    endfunction : feat

    // One-cycle event pulse, then time for the step to settle
    task automatic pulse(input int i);
        @(posedge CLK);
        EVT_IN[i] <= 1'b1;
        @(posedge CLK);
        EVT_IN <= 4'h0;
        repeat (4) @(posedge CLK);
    endtask : pulse

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {SYS_RST, PSEL, PENABLE, PWRITE, STREAMING} = 5'h10;
        PADDR = 8'h00;
        PWDATA = 32'h0;
        EVT_IN = 4'h0;
        repeat (12) @(posedge CLK);
        SYS_RST <= 1'b0;
        rdc(OFS_STATUS, 32'h0);
        apb(1'b0, 8'h3C, 32'h0);
        `CHK(perr, 1'b1)
        wr(OFS_FEAT_PICK, 32'h2);
        wr(OFS_FEAT_EN, 32'h1);
        wr(OFS_FEAT_PICK, 32'h3);
        wr(OFS_FEAT_EN, 32'h1);
        wr(OFS_CTRL, 32'h1);
        @(posedge CLK);
        `CHK(SETUP_ON, 1'b1)
        rdc(OFS_CLASS, 32'h20C0100C);
        wr(feat(7), 32'h1234);
        rdc(feat(7), 32'h0);
        wr(feat(0), 32'h1111);
        rdc(feat(0), 32'h1111);
        wr(feat(5), 32'h0055);
        rdc(feat(5), 32'h0055);
        wr(feat(4), 32'h0042);
        rdc(feat(4), 32'h0042);
        // Set 2 holds an out-of-range value and must not validate
        for (int s = 0; s < 3; s++) begin
            wr(OFS_SET_PICK, 32'(s));
            wr(OFS_PATH, 32'((s + 1) % 2) << PATH_NEXT_LSB);
            wr(feat(3), {16'h0, vals[s]});
            wr(OFS_CTRL, 32'h5);
            rdc(OFS_STATUS, st_exp[s]);
        end
        wr(OFS_PATH_PICK, 32'h1);
        rdc(OFS_PATH_PICK, 32'h0);
        wr(OFS_FIRST_SET, 32'h0);
        wr(OFS_CTRL, 32'h0);
        rdc(OFS_STATUS, 32'h00030001);
        wr(OFS_SET_PICK, 32'h1);
        wr(OFS_CTRL, 32'h8);
        rdc(feat(3), 32'h0300);
        STREAMING <= 1'b1;
        wr(OFS_CTRL, 32'h2);
        @(posedge CLK);
        `CHK(RUN_ON, 1'b0)
        STREAMING <= 1'b0;
        wr(OFS_CTRL, 32'h2);
        @(posedge CLK);
        `CHK(RUN_ON, 1'b1)
        `CHK(ACTIVE_SET, 3'h0)
        `CHK(FEAT_VALUE[3], 16'h0100)
        `CHK(FEAT_VALUE[5], 16'h0)
        wr(feat(4), 32'h0007);
        rdc(feat(4), 32'h0042);
        wr(feat(0), 32'h2222);
        rdc(feat(0), 32'h2222);
        pulse(1);
        `CHK(ACTIVE_SET, 3'h0)
        pulse(0);
        `CHK(ACTIVE_SET, 3'h1)
        pulse(0);
        `CHK(ACTIVE_SET, 3'h0)
        wr(OFS_CTRL, 32'h0);
        @(posedge CLK);
        `CHK(RUN_ON, 1'b0)
        // A changed fixed value makes set 0 stale once set 1 is stored again
        wr(feat(7), 32'h0077);
        wr(OFS_CTRL, 32'h1);
        wr(OFS_CTRL, 32'h5);
        rdc(OFS_STATUS, 32'h00020002);
        summarize();
    end
endmodule : acqseq_top_tb_top
